// ---- rtl/asx_pkg.sv ----
package asx_pkg;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 4;
   localparam int CLK_PERIOD_NS = 10;
   // Least times, ns
   localparam int T_ADDR_SETUP_NS = 0;
   localparam int T_WRITE_PULSE_NS = 14;
   localparam int T_WE_HIGHZ_NS = 5;
   localparam int T_DATA_SETUP_NS = 10;
   localparam int T_WRITE_RECOVERY_NS = 0;
   localparam int T_READ_CYCLE_NS = 15;
   localparam int T_OUT_ACTIVE_NS = 5;
   localparam int T_POWER_UP_NS = 0;
   // Derived cycle counts, rounded up, at least one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int WP_CYC = cyc_up(T_WRITE_PULSE_NS);
   localparam int WP_OE_CYC = (cyc_up(T_WE_HIGHZ_NS + T_DATA_SETUP_NS) > WP_CYC) ?
      cyc_up(T_WE_HIGHZ_NS + T_DATA_SETUP_NS) : WP_CYC;
   localparam int RD_CYC = cyc_up(T_READ_CYCLE_NS);
   localparam int GAP_CYC = cyc_up(T_OUT_ACTIVE_NS);
   localparam int CNT_W = 4;
   typedef enum logic [2:0] {
      ASX_IDLE = 3'b000,
      ASX_RD = 3'b001,
      ASX_WSET = 3'b010,
      ASX_WPULSE = 3'b011,
      ASX_WEND = 3'b100,
      ASX_GAP = 3'b101
   } asx_state_t;
endpackage

// ---- rtl/asx_ctrl.sv ----
`timescale 1ns/1ps
// Contract
// - The controller keeps strobe or select high whenever the address changes.
// - The controller drives no write data while the memory may still drive the bus.
// - With the output gate low, the strobe pulse covers turn-off delay plus data set-up.
// - The strobe stays high for the whole of every read.
// - The address is valid no later than select falls on a read.
module asx_ctrl
   import asx_pkg::*;
#(
   parameter bit GATE_LOW_IN_WRITE = 1'b0
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // Request port
   input wire logic REQ_VALID,
   input wire logic REQ_WRITE,
   input wire logic [ADDR_W-1:0] REQ_ADDR,
   input wire logic [DATA_W-1:0] REQ_WDATA,
   output logic REQ_READY,
   output logic RSP_VALID,
   output logic [DATA_W-1:0] RSP_RDATA,
   // Memory pins
   output logic [ADDR_W-1:0] MEM_ADDR,
   output logic MEM_SEL_N,
   output logic MEM_WSTB_N,
   output logic MEM_OGATE_N,
   input wire logic [DATA_W-1:0] MEM_DQ_IN,
   output logic [DATA_W-1:0] MEM_DQ_OUT,
   output logic MEM_DQ_OE
);
   asx_state_t state_reg;
   asx_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [CNT_W-1:0] wp_len;
   logic take;
   logic cnt_last;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic sel_n_reg;
   logic wstb_n_reg;
   logic ogate_n_reg;
   logic dq_oe_reg;
   logic rsp_valid_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] dq_s1_reg;
   logic [DATA_W-1:0] dq_s2_reg;

   // ****************************************
   // Pin input synchroniser
   // ****************************************
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dq_s1_reg <= '0;
         dq_s2_reg <= '0;
      end else if (CE) begin
         dq_s1_reg <= MEM_DQ_IN;
         dq_s2_reg <= dq_s1_reg;
      end
   end

   // ****************************************
   // Request decode
   // ****************************************
   assign wp_len = GATE_LOW_IN_WRITE ? CNT_W'(WP_OE_CYC) : CNT_W'(WP_CYC);
   assign REQ_READY = (state_reg == ASX_IDLE);
   assign take = REQ_VALID && (state_reg == ASX_IDLE);
   assign cnt_last = (cnt_reg == CNT_W'(1));

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ASX_IDLE: begin
            if (take) begin
               state_next = REQ_WRITE ? ASX_WSET : ASX_RD;
            end
         end
         ASX_RD: begin
            if (cnt_last) begin
               state_next = ASX_GAP;
            end
         end
         ASX_WSET: begin
            state_next = ASX_WPULSE;
         end
         ASX_WPULSE: begin
            if (cnt_last) begin
               state_next = ASX_WEND;
            end
         end
         ASX_WEND: begin
            state_next = ASX_GAP;
         end
         ASX_GAP: begin
            if (cnt_last) begin
               state_next = ASX_IDLE;
            end
         end
         default: begin
            state_next = ASX_IDLE;
         end
      endcase
   end

   always_comb begin
      cnt_next = cnt_reg;
      unique case (state_reg)
         ASX_IDLE: begin
            if (take && !REQ_WRITE) begin
               // One extra cycle covers the synchroniser delay
               cnt_next = CNT_W'(RD_CYC + 1);
            end
         end
         ASX_RD: begin
            cnt_next = cnt_last ? CNT_W'(GAP_CYC) : cnt_reg - CNT_W'(1);
         end
         ASX_WSET: begin
            cnt_next = wp_len;
         end
         ASX_WEND: begin
            cnt_next = CNT_W'(GAP_CYC);
         end
         ASX_WPULSE, ASX_GAP: begin
            if (!cnt_last) begin
               cnt_next = cnt_reg - CNT_W'(1);
            end
         end
         default: begin
            cnt_next = '0;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= ASX_IDLE;
         cnt_reg <= '0;
      end else if (CE) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // ****************************************
   // Address and write data
   // ****************************************
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         addr_reg <= '0;
         wdata_reg <= '0;
      end else if (CE && take) begin
         // Address moves only while the strobe is high; on a read select falls on the same edge
         addr_reg <= REQ_ADDR;
         if (REQ_WRITE) begin
            wdata_reg <= REQ_WDATA;
         end
      end
   end

   // ****************************************
   // Select
   // ****************************************
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sel_n_reg <= 1'b1;
      end else if (CE) begin
         if (take && !REQ_WRITE) begin
            sel_n_reg <= 1'b0;
         end else if (state_reg == ASX_WSET) begin
            sel_n_reg <= 1'b0;
         end else if (cnt_last && (state_reg == ASX_RD || state_reg == ASX_WPULSE)) begin
            sel_n_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // Write strobe
   // ****************************************
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wstb_n_reg <= 1'b1;
      end else if (CE) begin
         if (state_reg == ASX_WSET) begin
            // Strobe and select fall together so the memory never drives
            wstb_n_reg <= 1'b0;
         end else if (state_reg != ASX_WPULSE || cnt_last) begin
            wstb_n_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // Output gate
   // ****************************************
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ogate_n_reg <= 1'b1;
      end else if (CE) begin
         if (take) begin
            ogate_n_reg <= REQ_WRITE ? !GATE_LOW_IN_WRITE : 1'b0;
         end else if ((state_reg == ASX_RD && cnt_last) || state_reg == ASX_WEND) begin
            ogate_n_reg <= 1'b1;
         end
      end
   end

   // ****************************************
   // Data bus drive
   // ****************************************
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dq_oe_reg <= 1'b0;
      end else if (CE) begin
         if (state_reg == ASX_WPULSE) begin
            // Data drives only once the strobe is low and outputs are off
            dq_oe_reg <= 1'b1;
         end else if (state_reg == ASX_WEND) begin
            // Data hold after the overlap ends, then release the bus
            dq_oe_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Read response
   // ****************************************
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rsp_valid_reg <= 1'b0;
         rdata_reg <= '0;
      end else if (CE) begin
         rsp_valid_reg <= (state_reg == ASX_RD) && cnt_last;
         if ((state_reg == ASX_RD) && cnt_last) begin
            rdata_reg <= dq_s2_reg;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign MEM_ADDR = addr_reg;
   assign MEM_SEL_N = sel_n_reg;
   assign MEM_WSTB_N = wstb_n_reg;
   assign MEM_OGATE_N = ogate_n_reg;
   assign MEM_DQ_OUT = wdata_reg;
   assign MEM_DQ_OE = dq_oe_reg;
   assign RSP_VALID = rsp_valid_reg;
   assign RSP_RDATA = rdata_reg;
endmodule

// ---- test/asx_ctrl_monitor.sv ----
`timescale 1ns/1ps
module asx_ctrl_monitor import asx_pkg::*; (
   // Watched ports
   input wire logic CLK, RST, CE, REQ_VALID, REQ_WRITE, REQ_READY,
   input wire logic [ADDR_W-1:0] REQ_ADDR, MEM_ADDR,
   input wire logic MEM_SEL_N, MEM_WSTB_N, MEM_OGATE_N, MEM_DQ_OE
);
   // ****
   // Pin order checks
   // ****
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   logic rd_take, mem_out;
   assign rd_take = CE && REQ_VALID && REQ_READY && !REQ_WRITE;
   assign mem_out = !MEM_SEL_N && MEM_WSTB_N && !MEM_OGATE_N;
   AST_ADDR_SAFE: assert property ($changed(MEM_ADDR) |->
      (MEM_SEL_N || MEM_WSTB_N) && $past(MEM_SEL_N || MEM_WSTB_N)) else $error("address moved in a write");
   AST_NO_FIGHT: assert property (MEM_DQ_OE |-> !mem_out && !$past(mem_out))
      else $error("bus driven while memory may drive");
   AST_PULSE: assert property ($fell(MEM_WSTB_N) |-> !MEM_WSTB_N [*2])
      else $error("write strobe too short");
   AST_RD_WSTB: assert property (rd_take |=> MEM_WSTB_N [*4])
      else $error("strobe low in a read");
   AST_RD_ADDR: assert property (rd_take |=> MEM_ADDR == $past(REQ_ADDR) && !MEM_SEL_N ##1 $stable(MEM_ADDR) [*3])
      else $error("read address late or moving");
   cover property (rd_take);
   cover property ($fell(MEM_WSTB_N));
   cover property (MEM_DQ_OE);
endmodule
bind asx_ctrl asx_ctrl_monitor u_mon (.*);

// ---- test/asx_sram_model.sv ----
`timescale 1ns/1ps
module asx_sram_model import asx_pkg::*; (
   // Pins
   input wire logic CLK, MEM_SEL_N, MEM_WSTB_N, MEM_OGATE_N, MEM_DQ_OE,
   input wire logic [ADDR_W-1:0] MEM_ADDR,
   input wire logic [DATA_W-1:0] MEM_DQ_OUT,
   output logic [DATA_W-1:0] MEM_DQ_IN
);
   // ****
   // Memory array and bus
   // ****
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Kept while deselected
   logic drv;
   logic flip = 1'b0;
   always @(posedge CLK) flip <= ~flip;
   always @* if (!MEM_SEL_N && !MEM_WSTB_N && MEM_DQ_OE) mem[MEM_ADDR] = MEM_DQ_OUT;
   assign drv = !MEM_SEL_N && MEM_WSTB_N && !MEM_OGATE_N;
   // Floating bus shows a toggling pattern
   assign MEM_DQ_IN = (drv && MEM_DQ_OE) ? 'x : drv ? mem[MEM_ADDR] : MEM_DQ_OE ? MEM_DQ_OUT : {DATA_W{flip}};
endmodule

// ---- test/test_async_sram_16k_x4_access.sv ----
`timescale 1ns/1ps
module test_async_sram_16k_x4_access;
   import asx_pkg::*;
   // ****
   // Bench
   // ****
   logic CLK = 0, RST = 1, CE = 1, REQ_VALID = 0, REQ_WRITE = 0;
   logic [ADDR_W-1:0] REQ_ADDR = '0;
   logic [DATA_W-1:0] REQ_WDATA = '0;
   logic REQ_READY, RSP_VALID, MEM_SEL_N, MEM_WSTB_N, MEM_OGATE_N, MEM_DQ_OE;
   logic [DATA_W-1:0] RSP_RDATA, MEM_DQ_IN, MEM_DQ_OUT;
   logic [ADDR_W-1:0] MEM_ADDR;
   logic [ADDR_W-1:0] adr [3] = '{14'h0000, 14'h3fff, 14'h1555};
   logic [DATA_W-1:0] dat [3] = '{4'ha, 4'h5, 4'hf};
   int miscompares = 0, n_checks = 0;
   asx_ctrl u_dut (.*);
   asx_sram_model u_mem (.*);
   initial forever #5 CLK = ~CLK;
   task automatic end_sim(input bit hang);
      if (hang) miscompares++;
      if (miscompares == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [DATA_W-1:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Read returns in the cycle of the response pulse
   task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(negedge CLK);
      {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA} = {1'b1, w, a, d};
      for (n = 0; n < 20 && REQ_READY !== 1'b1; n++) @(negedge CLK);
      if (n == 20) end_sim(1);
      @(negedge CLK);
      REQ_VALID = 0;
      for (n = 0; n < 20 && (w ? REQ_READY : RSP_VALID) !== 1'b1; n++) @(negedge CLK);
      if (n == 20) end_sim(1);
   endtask
   task automatic t_fill;
      for (int i = 0; i < 3; i++) req(1, adr[i], dat[i]);
      for (int i = 0; i < 3; i++) begin
         req(0, adr[i], 4'h0);
         chk(RSP_RDATA, dat[i]);
      end
   endtask
   task automatic t_over;
      req(1, adr[2], 4'h3);
      req(1, adr[2], 4'hc);
      req(0, adr[1], 4'h0);
      chk(RSP_RDATA, dat[1]);
      req(0, adr[2], 4'h0);
      chk(RSP_RDATA, 4'hc);
   endtask
   // Clock enable low freezes a read in mid-flight
   task automatic t_freeze;
      int n;
      req(1, adr[0], 4'h6);
      @(negedge CLK);
      {REQ_VALID, REQ_WRITE, REQ_ADDR} = {1'b1, 1'b0, adr[0]};
      @(negedge CLK);
      {REQ_VALID, CE} = 2'b10;
      repeat (5) @(negedge CLK);
      chk({MEM_SEL_N, MEM_WSTB_N, MEM_OGATE_N, REQ_READY}, 4'h4);
      chk({RSP_VALID, MEM_DQ_OE, 2'b00}, 4'h0);
      CE = 1;
      for (n = 0; n < 20 && RSP_VALID !== 1'b1; n++) @(negedge CLK);
      if (n == 20) end_sim(1);
      chk(RSP_RDATA, 4'h6);
   endtask
   // Reset in the middle of a write returns the pins to idle
   task automatic t_rst;
      int n;
      @(negedge CLK);
      {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_WDATA} = {1'b1, 1'b1, adr[2], 4'h9};
      for (n = 0; n < 20 && REQ_READY !== 1'b1; n++) @(negedge CLK);
      if (n == 20) end_sim(1);
      @(negedge CLK);
      REQ_VALID = 0;
      @(negedge CLK);
      RST = 1;
      @(negedge CLK);
      chk({MEM_SEL_N, MEM_WSTB_N, MEM_OGATE_N, MEM_DQ_OE}, 4'he);
      chk({REQ_READY, RSP_VALID, 2'b00}, 4'h8);
      RST = 0;
      @(negedge CLK);
      chk({MEM_SEL_N, MEM_WSTB_N, REQ_READY, MEM_DQ_OE}, 4'he);
      req(0, adr[1], 4'h0);
      chk(RSP_RDATA, dat[1]);
   endtask
   initial begin
      repeat (20) @(negedge CLK);
      RST = 0;
      t_fill();
      t_over();
      t_freeze();
      t_rst();
      end_sim(0);
   end
endmodule
